// ---- rtl/mlm_defs.svh ----
// Offsets, field positions, reset values and step counts of the load measurement block
`ifndef MLM_DEFS_SVH
`define MLM_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define MLM_AXI_AW          5
`define MLM_OFS_CTRL        5'h00
`define MLM_OFS_RESULT      5'h04
`define MLM_OFS_IRQ_STS     5'h08
`define MLM_OFS_IRQ_MSK     5'h0c
`define MLM_RESP_OKAY       2'h0
`define MLM_RESP_SLVERR     2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MLM_CTRL_FILT_BIT   8
`define MLM_CTRL_LSPD_BIT   9
`define MLM_RES_STALL_BIT   16
`define MLM_IRQ_NEW_BIT     0
`define MLM_IRQ_STALL_BIT   1

// ----------------------------------------
// Values and counts
// ----------------------------------------
`define MLM_RESULT_RST      10'h3ff
`define MLM_RESULT_MAX      10'h3ff
`define MLM_OFFSET_SHIFT    4
`define MLM_DIV3_MUL        12'haab
`define MLM_DIV3_SHIFT      13
`define MLM_STD_STEPS       4'h2
`define MLM_FILT_STEPS      4'h6

`endif

// ---- rtl/mlm_pkg.sv ----
// Types of the load measurement block
package mlm_pkg;

   // ----------------------------------------
   // Averaging phase
   // ----------------------------------------
   typedef enum logic [1:0] {
      MLM_PH_FIRST  = 2'b00,
      MLM_PH_SECOND = 2'b01,
      MLM_PH_THIRD  = 2'b10
   } mlm_avg_ph_type;

   // ----------------------------------------
   // Top state
   // ----------------------------------------
   typedef struct packed {
      logic           step_odd;
      logic [9:0]     prev_raw;
      mlm_avg_ph_type avg_ph;
      logic [11:0]    acc;
      logic           smp_vld;
      logic [9:0]     smp;
      logic [6:0]     offset;
      logic           filt_en;
      logic           lspd_sel;
      logic           aw_got;
      logic           w_got;
      logic [4:0]     waddr;
      logic [31:0]    wdata;
      logic [3:0]     wstrb;
      logic           bvalid;
      logic [1:0]     bresp;
      logic           rvalid;
      logic [1:0]     rresp;
      logic [31:0]    rdata;
      logic [1:0]     irq_sts;
      logic [1:0]     irq_msk;
      logic           irq;
   } mlm_top_state_type;

   // ----------------------------------------
   // Result stage state
   // ----------------------------------------
   typedef struct packed {
      logic [9:0] result;
      logic       stall;
      logic       vld;
   } mlm_calc_state_type;

endpackage

// ---- rtl/mlm_meas_if.sv ----
// Sample and result carrier between the sequencer and the result stage
`timescale 1ns/1ns
interface mlm_meas_if;
   logic       smp_vld;
   logic [9:0] smp;
   logic [6:0] offset;
   logic [9:0] result;
   logic       stall;
   logic       res_vld;

   modport src (output smp_vld, output smp, output offset, input result, input stall, input res_vld);
   modport calc (input smp_vld, input smp, input offset, output result, output stall, output res_vld);
endinterface

// ---- rtl/mlm_calc.sv ----
// Result stage: applies the threshold offset, saturates and flags a stall
`timescale 1ns/1ns
`include "mlm_defs.svh"
module mlm_calc (
   input  wire logic   ref_clk_i,
   input  wire logic   arst_n_i,
   input  wire logic   ce_i,
   mlm_meas_if.calc    meas
);

   mlm_pkg::mlm_calc_state_type r;
   mlm_pkg::mlm_calc_state_type n;
   logic signed [11:0]          sum;

   // ----------------------------------------
   // Offset and saturation
   // ----------------------------------------
   always_comb begin
      n   = r;
      sum = $signed({2'h0, meas.smp}) + ($signed({{5{meas.offset[6]}}, meas.offset}) <<< `MLM_OFFSET_SHIFT);
      if (ce_i) begin
         n.vld = meas.smp_vld;
         if (meas.smp_vld) begin
            if (sum <= 12'sh000) begin
               n.result = 10'h000;
            end else if (sum >= $signed({2'h0, `MLM_RESULT_MAX})) begin
               n.result = `MLM_RESULT_MAX;
            end else begin
               n.result = sum[9:0];
            end
            n.stall = (n.result == 10'h000);
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r        <= '0;
         r.result <= `MLM_RESULT_RST;
      end else begin
         r <= n;
      end
   end

   assign meas.result  = r.result;
   assign meas.stall   = r.stall;
   assign meas.res_vld = r.vld;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_zero_load: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      meas.smp_vld && ce_i && sum <= 12'sh000 |=> r.result == 10'h000 && r.stall)
      else $error("Result not zero at full load");
   a_result_top: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      meas.smp_vld && ce_i && sum >= 12'sh3ff |=> r.result == 10'h3ff && !r.stall)
      else $error("Result not saturated at 1023");
   a_offset_neutral: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      meas.smp_vld && ce_i && meas.offset == 7'h00 |=> r.result == $past(meas.smp))
      else $error("Zero offset changed the sample");
endmodule

// ---- rtl/mlm_top.sv ----
// Motor load measurement: sampling sequencer, averaging, register slave and interrupt
// ----------------------------------------
// Overview of operation
// - Result falls with load, zero at maximum
// - Result unsigned, 0 to 1023
// - Stall output high when result is zero
// - Standard mode updates every two fullsteps
// - Filter averages three measurements, six fullsteps
// - Signed offset shifts sensitivity, zero is neutral
// - Low speed select smooths successive samples
// ----------------------------------------
`timescale 1ns/1ns
`include "mlm_defs.svh"
module mlm_top (
   input  wire logic                      ref_clk_i,
   input  wire logic                      arst_n_i,
   input  wire logic                      ce_i,
   input  wire logic                      fullstep_i,
   input  wire logic [9:0]                raw_load_i,
   input  wire logic [`MLM_AXI_AW-1:0]    s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [`MLM_AXI_AW-1:0]    s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic [9:0]                     load_result_o,
   output logic                           stall_indicator_out_o,
   output logic                           irq_o
);

   mlm_pkg::mlm_top_state_type r;
   mlm_pkg::mlm_top_state_type n;
   mlm_meas_if                 meas ();

   default clocking chk_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   logic [10:0]             pair_sum;
   logic [9:0]              meas_val;
   logic [11:0]             acc_sum;
   logic [23:0]             div_prod;
   logic                    do_write;
   logic [`MLM_AXI_AW-1:0]  wr_ofs;
   logic [`MLM_AXI_AW-1:0]  rd_ofs;
   logic [31:0]             rd_word;
   logic                    rd_hit;

   // ----------------------------------------
   // Result stage
   // ----------------------------------------
   mlm_calc u_calc (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .ce_i      (ce_i),
      .meas      (meas)
   );

   assign meas.smp_vld = r.smp_vld;
   assign meas.smp     = r.smp;
   assign meas.offset  = r.offset;

   // ----------------------------------------
   // Sample shaping
   // ----------------------------------------
   always_comb begin
      pair_sum = {1'b0, r.prev_raw} + {1'b0, raw_load_i};
      meas_val = r.lspd_sel ? pair_sum[10:1] : raw_load_i;
      acc_sum  = r.acc + {2'h0, meas_val};
      div_prod = acc_sum * `MLM_DIV3_MUL;
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb begin
      rd_ofs  = {s_axi_araddr[`MLM_AXI_AW-1:2], 2'h0};
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (rd_ofs)
         `MLM_OFS_CTRL: begin
            rd_word[6:0]                = r.offset;
            rd_word[`MLM_CTRL_FILT_BIT] = r.filt_en;
            rd_word[`MLM_CTRL_LSPD_BIT] = r.lspd_sel;
         end
         `MLM_OFS_RESULT: begin
            rd_word[9:0]                = meas.result;
            rd_word[`MLM_RES_STALL_BIT] = meas.stall;
         end
         `MLM_OFS_IRQ_STS: begin
            rd_word[1:0] = r.irq_sts;
         end
         `MLM_OFS_IRQ_MSK: begin
            rd_word[1:0] = r.irq_msk;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n        = r;
      wr_ofs   = {r.waddr[`MLM_AXI_AW-1:2], 2'h0};
      do_write = r.aw_got && r.w_got && !r.bvalid;
      if (ce_i) begin
         n.smp_vld = 1'b0;
         // Measurement every second fullstep
         if (fullstep_i) begin
            n.step_odd = ~r.step_odd;
            if (r.step_odd) begin
               n.prev_raw = raw_load_i;
               if (r.filt_en) begin
                  unique case (r.avg_ph)
                     mlm_pkg::MLM_PH_FIRST: begin
                        n.acc    = {2'h0, meas_val};
                        n.avg_ph = mlm_pkg::MLM_PH_SECOND;
                     end
                     mlm_pkg::MLM_PH_SECOND: begin
                        n.acc    = acc_sum;
                        n.avg_ph = mlm_pkg::MLM_PH_THIRD;
                     end
                     mlm_pkg::MLM_PH_THIRD: begin
                        n.smp     = div_prod[`MLM_DIV3_SHIFT+9:`MLM_DIV3_SHIFT];
                        n.smp_vld = 1'b1;
                        n.avg_ph  = mlm_pkg::MLM_PH_FIRST;
                     end
                     default: begin
                        n.avg_ph = mlm_pkg::MLM_PH_FIRST;
                     end
                  endcase
               end else begin
                  n.smp     = meas_val;
                  n.smp_vld = 1'b1;
                  n.avg_ph  = mlm_pkg::MLM_PH_FIRST;
               end
            end
         end
         // Write address and data, either order
         if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.waddr  = s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
         end
         if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
         end
         if (do_write) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = `MLM_RESP_OKAY;
            unique case (wr_ofs)
               `MLM_OFS_CTRL: begin
                  if (r.wstrb[0]) begin
                     n.offset = r.wdata[6:0];
                  end
                  if (r.wstrb[1]) begin
                     n.filt_en  = r.wdata[`MLM_CTRL_FILT_BIT];
                     n.lspd_sel = r.wdata[`MLM_CTRL_LSPD_BIT];
                     if (r.wdata[`MLM_CTRL_FILT_BIT] != r.filt_en) begin
                        n.avg_ph = mlm_pkg::MLM_PH_FIRST;
                     end
                  end
               end
               `MLM_OFS_RESULT: begin
                  n.bresp = `MLM_RESP_OKAY;
               end
               `MLM_OFS_IRQ_STS: begin
                  if (r.wstrb[0]) begin
                     n.irq_sts = r.irq_sts & ~r.wdata[1:0];
                  end
               end
               `MLM_OFS_IRQ_MSK: begin
                  if (r.wstrb[0]) begin
                     n.irq_msk = r.wdata[1:0];
                  end
               end
               default: begin
                  n.bresp = `MLM_RESP_SLVERR;
               end
            endcase
         end
         // Read channel
         if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_word;
            n.rresp  = rd_hit ? `MLM_RESP_OKAY : `MLM_RESP_SLVERR;
         end
         // Events set after the clear so a coincident event survives
         if (meas.res_vld) begin
            n.irq_sts[`MLM_IRQ_NEW_BIT] = 1'b1;
            if (meas.stall) begin
               n.irq_sts[`MLM_IRQ_STALL_BIT] = 1'b1;
            end
         end
         n.irq = |(n.irq_sts & n.irq_msk);
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready         = ce_i && !r.aw_got && !r.bvalid;
   assign s_axi_wready          = ce_i && !r.w_got && !r.bvalid;
   assign s_axi_bvalid          = r.bvalid;
   assign s_axi_bresp           = r.bresp;
   assign s_axi_arready         = ce_i && !r.rvalid;
   assign s_axi_rvalid          = r.rvalid;
   assign s_axi_rdata           = r.rdata;
   assign s_axi_rresp           = r.rresp;
   assign load_result_o         = meas.result;
   assign stall_indicator_out_o = meas.stall;
   assign irq_o                 = r.irq;

   // ----------------------------------------
   // Check helpers
   // ----------------------------------------
   logic [3:0] steps_cnt_r;
   logic       mode_chg_r;
   logic       irq_sts_stall_set;

   assign irq_sts_stall_set = n.irq_sts[`MLM_IRQ_STALL_BIT] || !ce_i;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         steps_cnt_r <= 4'h0;
         mode_chg_r  <= 1'b0;
      end else if (ce_i) begin
         if (r.smp_vld) begin
            steps_cnt_r <= fullstep_i ? 4'h1 : 4'h0;
            mode_chg_r  <= 1'b0;
         end else if (fullstep_i) begin
            steps_cnt_r <= steps_cnt_r + 4'h1;
         end
         if (n.filt_en != r.filt_en) begin
            mode_chg_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_stall_level: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      stall_indicator_out_o == (load_result_o == 10'h000))
      else $error("Stall output disagrees with result");
   a_std_interval: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      r.smp_vld && ce_i && !mode_chg_r && !r.filt_en |-> steps_cnt_r == 4'h2)
      else $error("Standard sample not after two fullsteps");
   a_filt_interval: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      r.smp_vld && ce_i && !mode_chg_r && r.filt_en |-> steps_cnt_r == 4'h6)
      else $error("Filtered sample not after six fullsteps");
   a_lspd_smooth: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      fullstep_i && ce_i && r.step_odd && !r.filt_en && r.lspd_sel
      |=> r.smp_vld && r.smp == 10'((11'($past(raw_load_i)) + 11'($past(r.prev_raw))) >> 1))
      else $error("Low speed sample not smoothed");
   a_lspd_plain: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      fullstep_i && ce_i && r.step_odd && !r.filt_en && !r.lspd_sel
      |=> r.smp_vld && r.smp == $past(raw_load_i))
      else $error("Standard sample altered");
   a_offset_store: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      do_write && ce_i && wr_ofs == `MLM_OFS_CTRL && r.wstrb[0]
      |=> r.offset == 7'($past(r.wdata)) ##1 (!r.smp_vld || meas.offset == r.offset))
      else $error("Offset write not taken");
   a_result_follow: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      r.smp_vld && ce_i && r.offset == 7'h00 && r.smp == 10'h000 |=> load_result_o == 10'h000 && irq_sts_stall_set)
      else $error("Full load did not give zero");
   a_result_hold: assert property (
      !r.smp_vld |=> $stable(load_result_o))
      else $error("Result moved without a sample");
   a_stall_sticky: assert property (
      meas.res_vld && meas.stall && ce_i |=> r.irq_sts[`MLM_IRQ_STALL_BIT])
      else $error("Zero result flag not set");

   // ----------------------------------------
   // Freeze, bus and interrupt checks
   // ----------------------------------------
   a_freeze_state: assert property (
      !ce_i |=> r == $past(r))
      else $error("State moved while frozen");
   a_freeze_ready: assert property (
      !ce_i |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("Ready high while frozen");
   a_write_answer: assert property (
      do_write && ce_i |=> s_axi_bvalid)
      else $error("Write response late");
   a_bvalid_drop: assert property (
      s_axi_bvalid && s_axi_bready && ce_i |=> !s_axi_bvalid)
      else $error("Write response not released");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read data late");
   a_rvalid_drop: assert property (
      s_axi_rvalid && s_axi_rready && ce_i |=> !s_axi_rvalid)
      else $error("Read data not released");
   a_unmapped_write: assert property (
      do_write && ce_i && wr_ofs >= 5'h10 |=> s_axi_bresp == `MLM_RESP_SLVERR)
      else $error("Unmapped write not refused");
   a_unmapped_read: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr >= 5'h10
      |=> s_axi_rresp == `MLM_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("Unmapped read not refused");
   a_new_sticky: assert property (
      meas.res_vld && ce_i |=> r.irq_sts[`MLM_IRQ_NEW_BIT])
      else $error("New result flag not set");
   a_sts_clear: assert property (
      do_write && ce_i && wr_ofs == `MLM_OFS_IRQ_STS && r.wstrb[0] && !meas.res_vld
      |=> (r.irq_sts & 2'($past(r.wdata))) == 2'h0)
      else $error("Status bits not cleared");
   a_mask_store: assert property (
      do_write && ce_i && wr_ofs == `MLM_OFS_IRQ_MSK && r.wstrb[0] |=> r.irq_msk == 2'($past(r.wdata)))
      else $error("Mask write not taken");
   a_irq_level: assert property (
      irq_o == |(r.irq_sts & r.irq_msk))
      else $error("Interrupt level wrong");

   c_freeze: cover property ($fell(ce_i));
   c_std_meas: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) r.smp_vld && !r.filt_en);
   c_filt_meas: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) r.smp_vld && r.filt_en);
   c_stall_seen: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $rose(stall_indicator_out_o));
   c_irq_raised: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $rose(irq_o));
endmodule

// ---- testbench/mlm_front_model.sv ----
// Motor front end model: fullstep pulses and raw load metric
`timescale 1ns/1ns
module mlm_front_model (
   input  wire logic       ref_clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       go_i,
   input  wire logic [9:0] load_i,
   output logic            fullstep_o,
   output logic [9:0]      raw_o
);
   logic       step_r;
   logic [9:0] raw_r;

   // Raw metric valid only with the step pulse, scrambled otherwise
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         step_r <= 1'b0;
         raw_r  <= 10'h000;
      end else begin
         step_r <= go_i;
         raw_r  <= go_i ? load_i : ~raw_r;
      end
   end

   assign fullstep_o = step_r;
   assign raw_o      = raw_r;
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking testbench of the load measurement block
`timescale 1ns/1ns
`include "mlm_defs.svh"
module tb_top;
   logic        clk, arst_n, ce, go, fullstep;
   logic [9:0]  load, raw, result;
   logic        stall, irq;
   logic [4:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   int          bad_count, checks_done;

   mlm_front_model front (.ref_clk_i(clk), .arst_n_i(arst_n), .go_i(go), .load_i(load),
                          .fullstep_o(fullstep), .raw_o(raw));
   mlm_top uut (.ref_clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .fullstep_i(fullstep), .raw_load_i(raw),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .load_result_o(result), .stall_indicator_out_o(stall), .irq_o(irq));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------
   // Report and compare
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tmo(input string name);
      bad_count++;
      $display("ERROR %s expected answer seen timeout", name);
      close_out();
   endtask

   // ----------------------------------------
   // Bus master
   // ----------------------------------------
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic awp, wp, bp, ta, tw;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      awp = 1'b1; wp = 1'b1; bp = 1'b1; n = 0;
      while (awp || wp) begin
         @(negedge clk);
         ta = awp && awready === 1'b1;
         tw = wp && wready === 1'b1;
         @(posedge clk);
         if (ta) begin awvalid <= 1'b0; awp = 1'b0; end
         if (tw) begin wvalid <= 1'b0; wp = 1'b0; end
         n++;
         if (n > 50) tmo("write address and data");
      end
      while (bp) begin
         @(negedge clk);
         if (bvalid === 1'b1) begin r = bresp; bp = 1'b0; end
         @(posedge clk);
         if (!bp) bready <= 1'b0;
         n++;
         if (n > 100) tmo("write response");
      end
   endtask

   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ap, rp, ta;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      ap = 1'b1; rp = 1'b1; n = 0;
      while (rp) begin
         @(negedge clk);
         ta = ap && arready === 1'b1;
         if (!ap && rvalid === 1'b1) begin d = rdata; r = rresp; rp = 1'b0; end
         @(posedge clk);
         if (ta) begin arvalid <= 1'b0; ap = 1'b0; end
         if (!rp) rready <= 1'b0;
         n++;
         if (n > 100) tmo("read");
      end
   endtask

   task automatic wr_ok(input logic [4:0] a, input logic [31:0] d);
      axi_wr(a, d, rs);
      chk("write response", `MLM_RESP_OKAY, rs);
      @(negedge clk);
   endtask

   task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
      axi_rd(a, rd, rs);
      chk(name, exp, rd);
      chk("read response", `MLM_RESP_OKAY, rs);
   endtask

   // Fullstep pulses at the given raw load, then settle
   task automatic steps(input logic [9:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         go <= 1'b1;
         load <= v;
         @(posedge clk);
         go <= 1'b0;
      end
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_reset();
      chk("result after reset", 32'h3ff, result);
      chk("stall after reset", 32'h0, stall);
      chk("irq after reset", 32'h0, irq);
      rd_chk("control reset", `MLM_OFS_CTRL, 32'h0);
      rd_chk("result reg reset", `MLM_OFS_RESULT, 32'h3ff);
      rd_chk("status reset", `MLM_OFS_IRQ_STS, 32'h0);
      rd_chk("mask reset", `MLM_OFS_IRQ_MSK, 32'h0);
   endtask

   task automatic sc_standard();
      steps(10'h1f4, 1);
      chk("result after one step", 32'h3ff, result);
      steps(10'h1f4, 1);
      chk("result after two steps", 32'h1f4, result);
      rd_chk("result reg", `MLM_OFS_RESULT, 32'h1f4);
      steps(10'h000, 2);
      chk("result at full load", 32'h0, result);
      chk("stall at full load", 32'h1, stall);
   endtask

   task automatic sc_offset();
      logic [6:0] ofs [4] = '{7'h01, 7'h40, 7'h3f, 7'h7f};
      logic [9:0] rw [4]  = '{10'h1f4, 10'h064, 10'h3e8, 10'h014};
      logic [9:0] ex [4]  = '{10'h204, 10'h000, 10'h3ff, 10'h004};
      for (int i = 0; i < 4; i++) begin
         wr_ok(`MLM_OFS_CTRL, {25'h0, ofs[i]});
         steps(rw[i], 2);
         chk("offset result", {22'h0, ex[i]}, result);
         chk("stall output", {31'h0, ex[i] == 10'h000}, stall);
         rd_chk("offset result reg", `MLM_OFS_RESULT, {15'h0, ex[i] == 10'h000, 6'h0, ex[i]});
         chk("irq while masked", 32'h0, irq);
      end
   endtask

   task automatic sc_filter();
      wr_ok(`MLM_OFS_CTRL, 32'h100);
      steps(10'h12c, 2);
      steps(10'h258, 2);
      chk("filter partial", 32'h004, result);
      steps(10'h385, 2);
      chk("filter average", 32'h258, result);
      wr_ok(`MLM_OFS_CTRL, 32'h200);
      steps(10'h190, 2);
      chk("low speed first", 32'h28a, result);
      steps(10'h0c8, 2);
      chk("low speed second", 32'h12c, result);
      wr_ok(`MLM_OFS_CTRL, 32'h0);
   endtask

   task automatic sc_irq();
      wr_ok(`MLM_OFS_IRQ_STS, 32'h3);
      chk("irq cleared", 32'h0, irq);
      wr_ok(`MLM_OFS_IRQ_MSK, 32'h1);
      steps(10'h2bc, 2);
      chk("irq new result", 32'h1, irq);
      rd_chk("status new", `MLM_OFS_IRQ_STS, 32'h1);
      wr_ok(`MLM_OFS_IRQ_STS, 32'h1);
      chk("irq after clear", 32'h0, irq);
      wr_ok(`MLM_OFS_IRQ_MSK, 32'h2);
      wr_ok(`MLM_OFS_CTRL, 32'h40);
      steps(10'h064, 2);
      chk("irq zero result", 32'h1, irq);
      rd_chk("status both", `MLM_OFS_IRQ_STS, 32'h3);
      wr_ok(`MLM_OFS_IRQ_MSK, 32'h0);
      chk("irq masked", 32'h0, irq);
      wr_ok(`MLM_OFS_IRQ_STS, 32'h3);
      rd_chk("status cleared", `MLM_OFS_IRQ_STS, 32'h0);
   endtask

   task automatic sc_bus_err();
      axi_wr(5'h10, 32'hffff, rs);
      chk("unmapped write resp", `MLM_RESP_SLVERR, rs);
      axi_rd(5'h14, rd, rs);
      chk("unmapped read resp", `MLM_RESP_SLVERR, rs);
      chk("unmapped read data", 32'h0, rd);
      wr_ok(`MLM_OFS_RESULT, 32'h155);
      rd_chk("result read only", `MLM_OFS_RESULT, 32'h10000);
   endtask

   task automatic sc_freeze();
      wr_ok(`MLM_OFS_CTRL, 32'h0);
      @(posedge clk);
      ce <= 1'b0;
      steps(10'h155, 2);
      chk("result while frozen", 32'h0, result);
      @(posedge clk);
      ce <= 1'b1;
      steps(10'h155, 2);
      chk("result after freeze", 32'h155, result);
      chk("stall after freeze", 32'h0, stall);
   endtask

   initial begin
      bad_count = 0; checks_done = 0;
      arst_n = 1'b0; ce = 1'b1; go = 1'b0; load = 10'h000;
      awaddr = 5'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
      araddr = 5'h0; arvalid = 1'b0; rready = 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      sc_reset();
      sc_standard();
      sc_offset();
      sc_filter();
      sc_irq();
      sc_bus_err();
      sc_freeze();
      close_out();
   end
endmodule
